// ### design/eeps_top.sv
// Program sequencer of a 512-byte nonvolatile array behind an AXI4-Lite slave.
// Assumes a single 100 MHz clock and the charge pump modelled as an internal delay.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "eeps_consts.svh"

// Functional notes
// [R01] Erased cells read one; a finished program pulse turns target bits zero.
// [R02] Only unprotected array bytes and the configuration byte can be altered.
// [R03] 512-byte array, high voltage made on chip, no external supply.
// [R04] Volatile config reloads from the nonvolatile byte after reset and every read of that byte.
// [R05] Delivered with all cells one and config bit 4 one: nothing protected.
// [R06] Host clears both erase selects and sets the latch bit first.
// [R07] Host then writes the data byte to the target array address.
// [R08] Host sets the voltage bit and holds it for the program time.
// [R09] Host waits the voltage fall time before touching the latch bit.
// [R10] Host clears the latch bit and repeats all seven steps per byte.
// [R11] Host should erase bits before programming them.
// [R12] Either erase select set means erase; both clear means program.
// [R13] Voltage bit cannot be set while latch is clear after a non-array write.
// [R14] Clearing voltage and latch bits together clears only the voltage bit.
// [R15] With latch set, array reads return latched data; later writes replace it.
// [R16] A flag records a latched array write and qualifies the voltage bit.
module eeps_top (
   input  wire logic              aclk,          // Bus clock.
   input  wire logic              aresetn,       // Synchronous reset, active low.
   input  wire logic [11:0]       awaddr,        // Write address.
   input  wire logic              awvalid,       // Write address valid.
   output logic                   awready,       // Write address ready.
   input  wire logic [31:0]       wdata,         // Write data.
   input  wire logic [3:0]        wstrb,         // Write strobes.
   input  wire logic              wvalid,        // Write data valid.
   output logic                   wready,        // Write data ready.
   output logic [1:0]             bresp,         // Write response.
   output logic                   bvalid,        // Write response valid.
   input  wire logic              bready,        // Write response ready.
   input  wire logic [11:0]       araddr,        // Read address.
   input  wire logic              arvalid,       // Read address valid.
   output logic                   arready,       // Read address ready.
   output logic [31:0]            rdata,         // Read data.
   output logic [1:0]             rresp,         // Read response.
   output logic                   rvalid,        // Read data valid.
   input  wire logic              rready,        // Read data ready.
   output eeps_pkg::eeps_ctrl_t   ctrl_state,    // Control bits; hv bit runs the pump.
   output logic [7:0]             config_state   // Volatile array configuration.
);
   import eeps_pkg::*;

   localparam logic [15:0] PGM_M1 = 16'(`EEPS_PGM_CYCLES - 1);

   eeps_ctrl_t ctrl;
   eeps_ctrl_t nc;
   eeps_sel_t  wsel;
   eeps_sel_t  rsel;
   logic [11:0] aw_addr;
   logic        aw_held;
   logic [7:0]  w_data;
   logic        w_strb0;
   logic        w_held;
   logic        wr_go;
   logic [9:0]  lat_index;
   logic [7:0]  lat_data;
   logic        lat_valid;
   logic        latchable;
   logic [15:0] pgm_cnt;
   logic        pgm_done;
   logic        commit;
   logic        erase;
   logic [7:0]  vcfg;
   logic        reload;
   logic        rd_nv_hs;
   logic [7:0]  arr_rd;
   logic [7:0]  nv_data;

   function automatic logic is_prot(input logic [9:0] idx, input logic [7:0] cfg);
      return (idx != `EEPS_NV_INDEX) && !cfg[`EEPS_BIT_UNPROT] && cfg[idx[8:7]];
   endfunction

   assign wsel      = eeps_decode(aw_addr);
   assign rsel      = eeps_decode(araddr);
   assign wr_go     = aw_held && w_held && !bvalid;
   assign nc        = eeps_ctrl_t'(w_data[3:0]);
   assign erase     = ctrl.erase_mode_sel_hi | ctrl.erase_mode_sel_lo; // [R12]
   assign rd_nv_hs  = arvalid && arready && (rsel == EEPS_SEL_NV);
   assign ctrl_state   = ctrl;
   assign config_state = vcfg;

   // Protected bytes and writes other than to the array or the configuration byte never become a programming target.
   assign latchable = wr_go && w_strb0 && ctrl.addr_data_latch_en && !ctrl.hv_program_on &&
                      (((wsel == EEPS_SEL_ARRAY) && !is_prot({1'b0, aw_addr[10:2]}, vcfg)) ||
                       (wsel == EEPS_SEL_NV)); // [R02] [R15]

   // The pump delay is modelled by a counter; the cell changes once, at the end.
   assign commit = ctrl.hv_program_on && !pgm_done && (pgm_cnt == PGM_M1) && lat_valid &&
                   !is_prot(lat_index, vcfg); // [R01] [R02] [R03]

   eeps_cell_array u_cells (
      .aclk     (aclk),
      .wr_en    (commit),
      .wr_index (lat_index),
      .wr_data  (lat_data),
      .erase    (erase),
      .rd_index (araddr[10:2]),
      .rd_data  (arr_rd),
      .nv_data  (nv_data)
   );

   // Write address and data are taken independently, response follows both.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_held <= 1'b1;
         aw_addr <= awaddr;
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !bvalid && !awready) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready  <= 1'b0;
         w_held  <= 1'b0;
         w_data  <= 8'h00;
         w_strb0 <= 1'b0;
      end else if (wvalid && wready) begin
         wready  <= 1'b0;
         w_held  <= 1'b1;
         w_data  <= wdata[7:0];
         w_strb0 <= wstrb[0];
      end else if (wr_go) begin
         w_held <= 1'b0;
      end else if (!w_held && !bvalid && !wready) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `EEPS_RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp  <= (wsel == EEPS_SEL_NONE) ? `EEPS_RESP_SLVERR : `EEPS_RESP_OKAY;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read channel; the array byte is the latched one while a target is held.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `EEPS_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= (rsel == EEPS_SEL_NONE) ? `EEPS_RESP_SLVERR : `EEPS_RESP_OKAY;
         case (rsel)
            EEPS_SEL_ARRAY: begin
               rdata <= {24'h00_0000, (ctrl.addr_data_latch_en && lat_valid) ? lat_data : arr_rd}; // [R15]
            end
            EEPS_SEL_CTRL: begin
               rdata <= {28'h000_0000, ctrl};
            end
            EEPS_SEL_NV: begin
               rdata <= {24'h00_0000, nv_data};
            end
            EEPS_SEL_VCFG: begin
               rdata <= {24'h00_0000, vcfg};
            end
            default: begin
               rdata <= 32'h0000_0000;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid && !arready) begin
         arready <= 1'b1;
      end
   end

   // Control register with its interlocks.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= eeps_ctrl_t'(`EEPS_CTRL_RST);
      end else if (wr_go && (wsel == EEPS_SEL_CTRL) && w_strb0) begin
         if (ctrl.hv_program_on) begin
            ctrl.hv_program_on <= nc.hv_program_on;
         end else begin
            ctrl.hv_program_on <= nc.hv_program_on && nc.addr_data_latch_en &&
                                  ctrl.addr_data_latch_en && lat_valid; // [R13] [R16]
         end
         // The latch cannot drop in the write that removes the high voltage.
         ctrl.addr_data_latch_en <= ctrl.hv_program_on ? 1'b1 : nc.addr_data_latch_en; // [R14]
         if (!ctrl.hv_program_on) begin
            ctrl.erase_mode_sel_hi <= nc.erase_mode_sel_hi; // [R12]
            ctrl.erase_mode_sel_lo <= nc.erase_mode_sel_lo;
         end
      end
   end

   // Latched target; a later valid write replaces it, dropping the latch clears it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lat_valid <= 1'b0;
         lat_index <= 10'h000;
         lat_data  <= 8'h00;
      end else if (!ctrl.addr_data_latch_en) begin
         lat_valid <= 1'b0;
      end else if (latchable) begin
         lat_valid <= 1'b1; // [R16]
         lat_index <= (wsel == EEPS_SEL_NV) ? `EEPS_NV_INDEX : {1'b0, aw_addr[10:2]}; // [R15]
         lat_data  <= w_data;
      end
   end

   // Program pulse timer; the pulse must last its full time before the cell changes.
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl.hv_program_on) begin
         pgm_cnt  <= 16'h0000;
         pgm_done <= 1'b0;
      end else if (!pgm_done) begin
         if (pgm_cnt == PGM_M1) begin
            pgm_done <= 1'b1;
         end else begin
            pgm_cnt <= pgm_cnt + 16'h0001;
         end
      end
   end

   // Volatile configuration is copied from the cell one cycle after the request.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vcfg   <= `EEPS_VCFG_RST;
         reload <= 1'b1;
      end else begin
         if (reload) begin
            vcfg <= nv_data; // [R04]
         end
         reload <= rd_nv_hs;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence nv_read_s;
      arvalid && arready && (rsel == EEPS_SEL_NV);
   endsequence

   sequence array_latched_read_s;
      arvalid && arready && (rsel == EEPS_SEL_ARRAY) && ctrl.addr_data_latch_en && lat_valid;
   endsequence

   hv_needs_latch_a: assert property (ctrl.hv_program_on |-> ctrl.addr_data_latch_en && lat_valid) // [R13]
      else $error("voltage bit on without a latched target");
   hv_rise_qual_a: assert property ($rose(ctrl.hv_program_on) |-> $past(lat_valid) && $past(ctrl.addr_data_latch_en)) // [R16]
      else $error("voltage bit rose without a latched write");
   latch_kept_a: assert property ($fell(ctrl.hv_program_on) |-> ctrl.addr_data_latch_en) // [R14]
      else $error("latch cleared together with the voltage bit");
   mode_frozen_a: assert property (ctrl.hv_program_on && $past(ctrl.hv_program_on) |->
                                   $stable(ctrl.erase_mode_sel_hi) && $stable(ctrl.erase_mode_sel_lo)) // [R12]
      else $error("erase select changed during a pulse");
   commit_time_a: assert property ($rose(ctrl.hv_program_on) |-> !commit [*8]) // [R01]
      else $error("cell altered before the pulse time");
   commit_protect_a: assert property (commit |-> (lat_index == `EEPS_NV_INDEX) || vcfg[`EEPS_BIT_UNPROT] || // [R02]
                                      (vcfg[lat_index[8:7]] == 1'b0))
      else $error("protected byte altered");
   cfg_reload_a: assert property (nv_read_s |-> ##2 vcfg == $past(nv_data, 1)) // [R04]
      else $error("config not reloaded after a read of the config byte");
   latched_read_a: assert property (array_latched_read_s |=> rvalid && rdata[7:0] == $past(lat_data)) // [R15]
      else $error("array read did not return the latched byte");
   resp_bound_a: assert property (wr_go |=> bvalid [*1] ##0 !aw_held && !w_held) // [R02]
      else $error("write response missing");

endmodule

`default_nettype wire

// ### shared/eeps_consts.svh
// Constants of the byte-programmable nonvolatile array sequencer.
// Assumes a 100 MHz bus clock and a 12-bit AXI4-Lite byte address.
`ifndef EEPS_CONSTS_SVH
`define EEPS_CONSTS_SVH

`define EEPS_ARRAY_BYTES      512
`define EEPS_ENTRIES          513
`define EEPS_NV_INDEX         10'h200
`define EEPS_OFF_CTRL         12'h800
`define EEPS_OFF_NVCFG        12'h804
`define EEPS_OFF_VCFG         12'h808
`define EEPS_BIT_HV           0
`define EEPS_BIT_LATCH        1
`define EEPS_BIT_MODE_LO      2
`define EEPS_BIT_MODE_HI      3
`define EEPS_BIT_UNPROT       4
`define EEPS_CTRL_RST         4'h0
`define EEPS_VCFG_RST         8'h00
`define EEPS_ERASED           8'hFF
`define EEPS_NV_FACTORY       8'hFF
`define EEPS_RESP_OKAY        2'h0
`define EEPS_RESP_SLVERR      2'h2
`define EEPS_CLK_PERIOD_NS    10
`define EEPS_T_PROGRAM_PULSE_NS 10000
`define EEPS_PGM_CYCLES ((`EEPS_T_PROGRAM_PULSE_NS + `EEPS_CLK_PERIOD_NS - 1) / `EEPS_CLK_PERIOD_NS)

`endif

// ### shared/eeps_pkg.sv
// Types of the nonvolatile array sequencer.
// Assumes eeps_consts.svh is on the include path.
`include "eeps_consts.svh"

package eeps_pkg;

   typedef struct packed {
      logic erase_mode_sel_hi;
      logic erase_mode_sel_lo;
      logic addr_data_latch_en;
      logic hv_program_on;
   } eeps_ctrl_t;

   typedef enum logic [2:0] {
      EEPS_SEL_ARRAY,
      EEPS_SEL_CTRL,
      EEPS_SEL_NV,
      EEPS_SEL_VCFG,
      EEPS_SEL_NONE
   } eeps_sel_t;

   function automatic eeps_sel_t eeps_decode(input logic [11:0] a);
      eeps_sel_t s;
      s = EEPS_SEL_NONE;
      if (a[11] == 1'b0) begin
         s = EEPS_SEL_ARRAY;
      end else if ({a[11:2], 2'h0} == `EEPS_OFF_CTRL) begin
         s = EEPS_SEL_CTRL;
      end else if ({a[11:2], 2'h0} == `EEPS_OFF_NVCFG) begin
         s = EEPS_SEL_NV;
      end else if ({a[11:2], 2'h0} == `EEPS_OFF_VCFG) begin
         s = EEPS_SEL_VCFG;
      end
      return s;
   endfunction

endpackage

// ### design/eeps_cell_array.sv
// Cell array: 512 user bytes plus the nonvolatile configuration byte.
// Assumes the sequencer issues one commit at a time on the bus clock.
`timescale 1ns/1ps
`default_nettype none
`include "eeps_consts.svh"

module eeps_cell_array (
   input  wire logic       aclk,      // Bus clock.
   input  wire logic       wr_en,     // One-cycle commit pulse.
   input  wire logic [9:0] wr_index,  // Entry to alter.
   input  wire logic [7:0] wr_data,   // Byte to program.
   input  wire logic       erase,     // Erase instead of program.
   input  wire logic [8:0] rd_index,  // Bus read entry.
   output logic      [7:0] rd_data,   // Bus read byte.
   output logic      [7:0] nv_data    // Configuration byte.
);

   logic [7:0] mem [`EEPS_ENTRIES];

   // Nonvolatile contents are not touched by reset; this is the delivered state.
   initial begin
      for (int i = 0; i < `EEPS_ENTRIES; i++) begin
         mem[i] = (i == `EEPS_ARRAY_BYTES) ? `EEPS_NV_FACTORY : `EEPS_ERASED; // [R05]
      end
   end

   // Programming can only pull bits to zero; erase returns the byte to ones.
   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem[wr_index] <= erase ? `EEPS_ERASED : (mem[wr_index] & wr_data); // [R01] [R12]
      end
   end

   assign rd_data = mem[{1'b0, rd_index}];
   assign nv_data = mem[`EEPS_NV_INDEX];

endmodule

`default_nettype wire

// ### sim/eeps_host_model.sv
// Host model: an AXI4-Lite master that runs the byte program sequence.
// Assumes one bus clock; it changes its outputs just after rising edges.
`timescale 1ns/1ps
`default_nettype none
`include "eeps_consts.svh"

module eeps_host_model #(
   parameter int T_FALL_CYCLES = 10,  // Wait for the voltage to fall.
   parameter int LIMIT         = 200  // Cycles allowed for one bus answer.
) (
   input  wire logic        aclk,     // Bus clock.
   output logic      [11:0] awaddr,   // Write address.
   output logic             awvalid,  // Write address valid.
   input  wire logic        awready,  // Write address ready.
   output logic      [31:0] wdata,    // Write data.
   output logic      [3:0]  wstrb,    // Write strobes.
   output logic             wvalid,   // Write data valid.
   input  wire logic        wready,   // Write data ready.
   input  wire logic [1:0]  bresp,    // Write response.
   input  wire logic        bvalid,   // Write response valid.
   output logic             bready,   // Write response ready.
   output logic      [11:0] araddr,   // Read address.
   output logic             arvalid,  // Read address valid.
   input  wire logic        arready,  // Read address ready.
   input  wire logic [31:0] rdata,    // Read data.
   input  wire logic [1:0]  rresp,    // Read response.
   input  wire logic        rvalid,   // Read data valid.
   output logic             rready,   // Read data ready.
   output logic             hang      // A bus answer never came.
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, hang} = '0;
   end

   // Address and data are offered together and each is dropped once taken.
   task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= 4'h1;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      r = 2'h3;
      for (n = 0; n < LIMIT; n++) begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            break;
         end
      end
      bready <= 1'b0;
      if (r === 2'h3) hang <= 1'b1;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      r = 2'h3;
      d = '0;
      for (n = 0; n < LIMIT; n++) begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            r = rresp;
            d = rdata;
            break;
         end
      end
      rready <= 1'b0;
      if (r === 2'h3) hang <= 1'b1;
   endtask

   // The seven steps for one byte; mode selects program (0) or erase.
   task automatic prog_byte(input logic [11:0] a, input logic [7:0] d, input logic [1:0] m);
      logic [1:0] r;
      wr(`EEPS_OFF_CTRL, {4'h0, m, 2'b10}, r);
      wr(a, d, r);
      wr(`EEPS_OFF_CTRL, {4'h0, m, 2'b11}, r);
      repeat (`EEPS_PGM_CYCLES + 4) @(posedge aclk);
      wr(`EEPS_OFF_CTRL, {4'h0, m, 2'b10}, r);
      repeat (T_FALL_CYCLES) @(posedge aclk);
      wr(`EEPS_OFF_CTRL, 8'h00, r);
   endtask
endmodule
`default_nettype wire

// ### sim/tb_eeprom_program_sequencer.sv
// Testbench of the nonvolatile array program sequencer.
// Assumes the host model drives the register bus; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "eeps_consts.svh"

module tb_eeprom_program_sequencer;
   import eeps_pkg::*;
   typedef struct packed {logic [11:0] a; logic [7:0] d; logic [1:0] r;} eeps_row_t;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, hang;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [7:0]  config_state;
   eeps_ctrl_t  ctrl_state;
   int          mismatches = 0;
   int          tests_run = 0;
   eeps_row_t   rows [4] = '{'{12'h000, 8'hFF, 2'h0}, '{12'h7FC, 8'hFF, 2'h0},
                             '{12'h808, 8'hFF, 2'h0}, '{12'h80C, 8'h00, 2'h2}};

   eeps_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .ctrl_state, .config_state);
   eeps_host_model host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .hang);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %0s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      host.rd(a, d, r);
      chk(d, {24'h0, exp}, "array byte");
   endtask

   task automatic reset_dut();
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge hang) begin
      mismatches++;
      finish_test();
   end

   initial begin
      aresetn = 1'b0;
      reset_dut();
      chk({28'h0, ctrl_state}, 32'h0, "ctrl after reset");
      chk({24'h0, config_state}, {24'h0, `EEPS_NV_FACTORY}, "config after reset");
      foreach (rows[i]) begin
         host.rd(rows[i].a, d, r);
         chk({30'h0, r}, {30'h0, rows[i].r}, "read response");
         if (rows[i].r === `EEPS_RESP_OKAY) chk(d, {24'h0, rows[i].d}, "read data");
      end
      $display("test reset_map done");
      host.wr(`EEPS_OFF_CTRL, 8'h02, r);
      host.wr(12'h014, 8'h5A, r);
      host.wr(12'h018, 8'hA5, r);
      host.rd(12'h100, d, r);
      chk(d, 32'hA5, "latched read");
      host.wr(`EEPS_OFF_CTRL, 8'h03, r);
      chk({28'h0, ctrl_state}, 32'h3, "hv after latched write");
      host.wr(`EEPS_OFF_CTRL, 8'h00, r);
      chk({28'h0, ctrl_state}, 32'h2, "latch kept while hv on");
      host.wr(`EEPS_OFF_CTRL, 8'h00, r);
      rd_chk(12'h018, 8'hFF);
      rd_chk(12'h014, 8'hFF);
      $display("test latch_abort done");
      host.wr(`EEPS_OFF_CTRL, 8'h02, r);
      host.wr(`EEPS_OFF_CTRL, 8'h03, r);
      chk({28'h0, ctrl_state}, 32'h2, "hv without latched write");
      host.wr(`EEPS_OFF_CTRL, 8'h00, r);
      host.wr(`EEPS_OFF_VCFG, 8'h00, r);
      chk({24'h0, config_state}, 32'hFF, "config is read only");
      host.wr(`EEPS_OFF_CTRL, 8'h01, r);
      chk({28'h0, ctrl_state}, 32'h0, "hv after non-array write");
      host.wr(12'h80C, 8'h00, r);
      chk({30'h0, r}, {30'h0, `EEPS_RESP_SLVERR}, "unmapped write");
      $display("test refusals done");
      host.prog_byte(12'h014, 8'hA5, 2'h0);
      rd_chk(12'h014, 8'hA5);
      host.prog_byte(12'h014, 8'h3C, 2'h0);
      rd_chk(12'h014, 8'h24);
      for (int m = 1; m < 4; m++) begin
         host.prog_byte(12'h014, 8'h00, 2'(m));
         rd_chk(12'h014, 8'hFF);
         host.prog_byte(12'h014, 8'h00, 2'h0);
         rd_chk(12'h014, 8'h00);
      end
      $display("test program_erase done");
      host.prog_byte(`EEPS_OFF_NVCFG, 8'hE1, 2'h0);
      chk({24'h0, config_state}, 32'hFF, "config before nv read");
      host.rd(`EEPS_OFF_NVCFG, d, r);
      chk(d, 32'hE1, "nv byte");
      repeat (3) @(posedge aclk);
      chk({24'h0, config_state}, 32'hE1, "config after nv read");
      host.prog_byte(12'h014, 8'hFF, 2'h1);
      rd_chk(12'h014, 8'h00);
      host.prog_byte(12'h320, 8'h0F, 2'h0);
      rd_chk(12'h320, 8'h0F);
      reset_dut();
      chk({24'h0, config_state}, 32'hE1, "config after second reset");
      rd_chk(12'h320, 8'h0F);
      $display("test protection done");
      finish_test();
   end
endmodule
`default_nettype wire
